// ==== dac_control_logic_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_control_logic_tb_top;
	logic mclk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, sb = 0, pd = 0;
	logic [0:0] addr_in = 0;
	logic [7:0] wdata_in = 0, rdata_out, code, r;
	logic pw, st, bf, iv, rdy;
	int bad_count = 0, checks = 0;
	always #50 mclk_in = ~mclk_in;
	// Debug halt held high throughout: conversions must carry on regardless
	dacctl_top dut_u (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.standby_in(sb), .power_down_in(pd), .clk_avail_in(1'b1), .debug_halt_in(1'b1),
		.core_power_out(pw), .core_code_out(code), .convert_start_out(st),
		.buffer_enable_out(bf), .internal_valid_out(iv), .ready_out(rdy));
	task cy(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task ck(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (e !== s)
		begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// Gap cycle after each access so no strobe is driven twice in one step
	task bus(input logic w, input logic [0:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= w;
		rd_in <= !w;
		cy(1);
		r = rdata_out;
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		cy(1);
	endtask
	task rc(input logic [0:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		ck("rdata", e, r);
	endtask
	task wp(input logic [7:0] e);
		int i;
		for (i = 0; i < 40 && st !== 1'b1; i++)
			cy(1);
		ck("start", 8'h01, {7'h00, st});
		ck("code", e, code);
		if (st !== 1'b1)
			summarize();
	endtask
	task summarize();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		cy(12);
		rst_n_in <= 1'b1;
		cy(1);
		rc(1'h0, 8'h00);
		rc(1'h1, 8'h00);
		bus(1'b1, 1'h1, 8'h5a);
		cy(14);
		ck("idle", 8'h00, {pw, st});
		bus(1'b1, 1'h0, 8'hff);
		rc(1'h0, 8'hc1);
		wp(8'h5a);
		ck("paths", 8'h03, {bf, iv});
		ck("ready", 8'h01, {7'h00, rdy});
		bus(1'b1, 1'h1, 8'ha5);
		rc(1'h1, 8'ha5);
		ck("warm", 8'ha5, code);
		sb <= 1'b1;
		cy(8);
		ck("stby run", 8'h01, {7'h00, pw});
		bus(1'b1, 1'h0, 8'h41);
		cy(8);
		ck("stby off", 8'h00, {pw, bf});
		sb <= 1'b0;
		wp(8'ha5);
		ck("buf back", 8'h01, {7'h00, bf});
		pd <= 1'b1;
		cy(8);
		ck("pdown", 8'h00, {pw, bf, iv, rdy});
		pd <= 1'b0;
		bus(1'b1, 1'h0, 8'h00);
		cy(4);
		ck("disable", 8'h00, {pw, iv});
		summarize();
	end
endmodule
`default_nettype wire

// ==== dacctl_defines.vh ====
`ifndef DACCTL_DEFINES_VH
`define DACCTL_DEFINES_VH
`define DACCTL_ADDR_W 1
`define DACCTL_OFS_CONTROL 1'h0
`define DACCTL_OFS_VALUE 1'h1
`define DACCTL_BIT_ENABLE 0
`define DACCTL_BIT_BUFFER 6
`define DACCTL_BIT_STANDBY 7
`define DACCTL_CONTROL_MASK 8'hc1
`define DACCTL_CONTROL_RESET 8'h00
`define DACCTL_VALUE_RESET 8'h00
`define DACCTL_STARTUP_NS 1000
`define DACCTL_CLK_NS 100
`define DACCTL_STARTUP_CYC 8'h0a
`define DACCTL_CNT_W 8
`endif

// ==== dacctl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module dacctl_props
(
	// Bus
	input wire mclk_in,
	input wire rst_n_in,
	input wire [0:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	// Core side
	input wire power_down_in,
	input wire core_power_out,
	input wire [7:0] core_code_out,
	input wire convert_start_out,
	input wire buffer_enable_out,
	input wire internal_valid_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("rdata not idle");
	ctrl_zero_a: assert property (rd_in && addr_in == 1'h0 |=> rdata_out[5:1] == 5'h00)
		else $error("reserved bits set");
	val_read_a: assert property (wr_in && addr_in == 1'h1 ##1 !wr_in ##1 rd_in && addr_in == 1'h1
		|=> rdata_out == $past(wdata_in, 3))
		else $error("value readback");
	warm_start_a: assert property (wr_in && addr_in == 1'h1 && internal_valid_out
		|-> ##2 convert_start_out && core_code_out == $past(wdata_in, 2))
		else $error("warm start late");
	off_a: assert property (wr_in && addr_in == 1'h0 && !wdata_in[0] |-> ##2 !core_power_out)
		else $error("disable ignored");
	pdown_a: assert property (power_down_in [*5] |-> !core_power_out && !buffer_enable_out)
		else $error("power down ignored");
	// Startup is ten cycles, so power must be on well before any start
	start_pow_a: assert property (convert_start_out |-> $past(core_power_out, 8))
		else $error("start before warm");
	valid_a: assert property (internal_valid_out |-> core_power_out)
		else $error("valid while off");
endmodule
bind dacctl_top dacctl_props p_u (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.rdata_out, .power_down_in, .core_power_out, .core_code_out, .convert_start_out,
	.buffer_enable_out, .internal_valid_out);
`default_nettype wire

// ==== dacctl_regbyte.v ====
`timescale 1ns/1ps
`default_nettype none
module dacctl_regbyte
(
	// Clock and reset
	input wire mclk_in,
	input wire rst_n_in,
	// Write side
	input wire we_in,
	input wire [7:0] mask_in,
	input wire [7:0] wdata_in,
	input wire [7:0] reset_value_in,
	// Stored value
	output reg [7:0] q_out
);
	// Mask keeps unimplemented bits at zero
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
			q_out <= 8'h00;
		else if (we_in)
			q_out <= (wdata_in & mask_in) | (reset_value_in & ~mask_in & 8'h00);
	end
endmodule
`default_nettype wire

// ==== dacctl_top.v ====
// Functional notes
// RULE1: Enable bit switches converter on/off
// RULE2: Enabled data write starts conversion immediately
// RULE3: Disabled data write stores; enable converts
// RULE4: Buffer bit drives pin output
// RULE5: Standby keeps running only with bit, clock
// RULE6: Standby stop powers down; wake needs startup
// RULE7: Power-down always disables converter and buffer
// RULE8: Internal output available whenever enabled; code raises internal_valid_out only once the startup count has reached zero
// RULE9: Data register eight bits, resets zero
// RULE10: Debug halt leaves converter untouched
// RULE11: Software sets routing, data before enabling
// RULE12: Clocked from the peripheral clock
// RULE13: Control bits one to five read zero
`timescale 1ns/1ps
`default_nettype none
`include "dacctl_defines.vh"
module dacctl_top
(
	// Clock and reset
	input wire mclk_in,
	input wire rst_n_in,
	// Register port
	input wire [`DACCTL_ADDR_W-1:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	// Sleep state from power manager
	input wire standby_in,
	input wire power_down_in,
	input wire clk_avail_in,
	input wire debug_halt_in,
	// Analogue core control
	output reg core_power_out,
	output reg [7:0] core_code_out,
	output reg convert_start_out,
	output reg buffer_enable_out,
	output reg internal_valid_out,
	output reg ready_out
);
	// Sleep inputs come from another block; synchronise them
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	wire [7:0] converter_control;
	wire [7:0] conversion_value;
	wire wr_ctrl;
	wire wr_value;
	wire enable;
	wire buf_bit;
	wire keep_running_in_standby;
	wire standby_s;
	wire pdown_s;
	wire clkok_s;
	wire active;
	reg active_prev_reg;
	reg [`DACCTL_CNT_W-1:0] start_cnt_reg;
	reg [`DACCTL_CNT_W-1:0] start_cnt_next;
	reg pending_reg;
	reg pending_next;
	reg [7:0] rdata_next;
	localparam [`DACCTL_CNT_W-1:0] STARTUP = `DACCTL_STARTUP_CYC;

	// Debug halt is deliberately not used
	always @(posedge mclk_in) // RULE12
	begin
		if (!rst_n_in)
		begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= {debug_halt_in, clk_avail_in, power_down_in, standby_in};
			sync2_reg <= sync1_reg;
		end
	end
	assign standby_s = sync2_reg[0];
	assign pdown_s = sync2_reg[1];
	assign clkok_s = sync2_reg[2];

	assign wr_ctrl = wr_in && (addr_in == `DACCTL_OFS_CONTROL);
	assign wr_value = wr_in && (addr_in == `DACCTL_OFS_VALUE);

	dacctl_regbyte u_ctrl
	(
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.we_in(wr_ctrl),
		.mask_in(`DACCTL_CONTROL_MASK), // RULE13
		.wdata_in(wdata_in),
		.reset_value_in(`DACCTL_CONTROL_RESET),
		.q_out(converter_control)
	);

	dacctl_regbyte u_value
	(
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.we_in(wr_value), // RULE9
		.mask_in(8'hff),
		.wdata_in(wdata_in),
		.reset_value_in(`DACCTL_VALUE_RESET),
		.q_out(conversion_value)
	);

	assign enable = converter_control[`DACCTL_BIT_ENABLE]; // RULE1
	assign buf_bit = converter_control[`DACCTL_BIT_BUFFER];
	assign keep_running_in_standby = converter_control[`DACCTL_BIT_STANDBY];

	// Powered when enabled unless sleep stops it; debug halt has no say
	assign active = enable && !pdown_s // RULE7 RULE10
		&& !(standby_s && !(keep_running_in_standby && clkok_s)); // RULE5

	// A start that arrives while warming up waits for the counter
	always @*
	begin
		start_cnt_next = start_cnt_reg;
		pending_next = pending_reg;
		if (!active)
		begin
			start_cnt_next = STARTUP;
			pending_next = 1'b0;
		end
		else
		begin
			if (!active_prev_reg)
				pending_next = 1'b1; // RULE3 RULE6
			if (start_cnt_reg != {`DACCTL_CNT_W{1'b0}})
				start_cnt_next = start_cnt_reg - {{(`DACCTL_CNT_W-1){1'b0}}, 1'b1}; // RULE6
			if (wr_value)
				pending_next = 1'b1; // RULE2
			if (pending_reg && start_cnt_reg == {`DACCTL_CNT_W{1'b0}} && !wr_value)
				pending_next = 1'b0;
		end
	end

	always @*
	begin
		rdata_next = 8'h00;
		if (rd_in)
		begin
			if (addr_in == `DACCTL_OFS_CONTROL)
				rdata_next = converter_control; // RULE13
			else
				rdata_next = conversion_value;
		end
	end

	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			active_prev_reg <= 1'b0;
			start_cnt_reg <= STARTUP;
			pending_reg <= 1'b0;
			rdata_out <= 8'h00;
			core_power_out <= 1'b0;
			core_code_out <= `DACCTL_VALUE_RESET;
			convert_start_out <= 1'b0;
			buffer_enable_out <= 1'b0;
			internal_valid_out <= 1'b0;
			ready_out <= 1'b0;
		end
		else
		begin
			active_prev_reg <= active;
			start_cnt_reg <= start_cnt_next;
			pending_reg <= pending_next;
			rdata_out <= rdata_next;
			core_power_out <= active; // RULE1 RULE6
			buffer_enable_out <= active && buf_bit; // RULE4 RULE6
			internal_valid_out <= active && start_cnt_reg == {`DACCTL_CNT_W{1'b0}}; // RULE8
			ready_out <= active && start_cnt_next == {`DACCTL_CNT_W{1'b0}};
			convert_start_out <= 1'b0;
			if (active && pending_reg && start_cnt_reg == {`DACCTL_CNT_W{1'b0}})
			begin
				convert_start_out <= 1'b1; // RULE2 RULE3
				core_code_out <= conversion_value;
			end
		end
	end
endmodule
`default_nettype wire
